// File: hdl/rqbe_pkg.sv
// constants, field layouts and carrier types for the rx queue and early receive block
package rqbe_pkg;

	// register byte addresses
	localparam logic [31:0] Q1_CTRL_ADDR  = 32'h0000_0104;
	localparam logic [31:0] Q_CFG_ADDR    = 32'h0000_0108;
	localparam logic [31:0] ERT_ADDR      = 32'h0000_2008;
	localparam logic [31:0] ERT_STAT_ADDR = 32'h0000_200C;

	// rx_queue1_control field positions
	localparam int FREE_THR_LSB = 8;
	localparam int FMT_LSB      = 10;
	localparam int BUFFER_SIZE_CODE_LSB    = 16;
	localparam int SIZE_EXTENSION_BIT     = 25;
	localparam int RSV26_BIT    = 26;
	localparam int FLEX_LSB     = 27;

	// early_receive_threshold field positions
	localparam int ERT_THR_LSB = 0;
	localparam int ERT_EN_BIT  = 13;
	localparam int ERT_HI_LSB  = 15;

	// queue config and status field positions
	localparam int CFG_VMQ_BIT  = 0;
	localparam int CFG_RING_LSB = 16;
	localparam int ST_REQ_BIT   = 16;
	localparam int ST_EARLY_BIT = 17;
	localparam int ST_HIT_BIT   = 18;

	// values after reset
	localparam logic [31:0] Q1_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ERT_RST     = 32'h0000_0000;
	localparam logic [15:0] RING_RST    = 16'h0000;

	// size arithmetic
	localparam int ERT_UNIT_SHIFT = 3;
	localparam int EXT_SHIFT      = 4;
	localparam int KB_SHIFT       = 10;
	localparam logic [15:0] BUF_2048 = 16'h0800;
	localparam logic [15:0] BUF_1024 = 16'h0400;
	localparam logic [15:0] BUF_512  = 16'h0200;
	localparam logic [15:0] BUF_256  = 16'h0100;

	localparam logic [1:0] FMT_LEGACY    = 2'h0;
	localparam logic [1:0] FMT_SPLIT     = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [3:0] flex;
		logic       rsv26;
		logic       size_extension;
		logic [1:0] buffer_size_code;
		logic [1:0] fmt;
		logic [1:0] free_thr;
	} rqbe_q1_ctrl_t;

	typedef struct packed {
		logic [6:0]  hi;
		logic        en;
		logic [12:0] thr;
	} rqbe_ert_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rqbe_bus_t;

	typedef struct packed {
		logic [15:0] bytes;
		logic        valid;
		logic        split;
	} rqbe_size_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_REQ  = 2'b10
	} rqbe_state_t;

endpackage

// File: hdl/rqbe_ahb_slave.sv
// ahb-lite slave front end: one wait state, registered read data, always okay
`timescale 1ns/1ps
module rqbe_ahb_slave (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	input  wire logic [31:0]      rdata,
	output rqbe_pkg::rqbe_bus_t   bus,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata
);
	import rqbe_pkg::*;

	logic        pend_q;
	logic        write_q;
	logic [31:0] addr_q;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pend_q    <= 1'b0;
			write_q   <= 1'b0;
			addr_q    <= 32'h0000_0000;
			hreadyout <= 1'b1;
		end else if (pend_q) begin
			pend_q    <= 1'b0;
			hreadyout <= 1'b1;
		end else if (hsel && hready && htrans == HTRANS_NONSEQ) begin
			pend_q    <= 1'b1;
			write_q   <= hwrite;
			addr_q    <= haddr;
			hreadyout <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (pend_q && !write_q) begin
			hrdata <= rdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	always_comb begin
		bus.wr    = pend_q && write_q;
		bus.rd    = pend_q && !write_q;
		bus.addr  = addr_q;
		bus.wdata = hwdata;
	end

endmodule

// File: hdl/rqbe_size_dec.sv
// queue one receive buffer size decode
`timescale 1ns/1ps
module rqbe_size_dec (
	input  rqbe_pkg::rqbe_q1_ctrl_t ctrl,
	output rqbe_pkg::rqbe_size_t    size
);
	import rqbe_pkg::*;

	logic [15:0] base;

	always_comb begin
		case (ctrl.buffer_size_code)
			2'h0: base = BUF_2048;
			2'h1: base = BUF_1024;
			2'h2: base = BUF_512;
			default: base = BUF_256;
		endcase
	end

	always_comb begin
		size = '0;
		if (ctrl.fmt == FMT_SPLIT) begin
			size.split = 1'b1;
			size.valid = 1'b1;
		end else if (ctrl.fmt == FMT_LEGACY) begin
			if (ctrl.flex != 4'h0) begin
				size.bytes = 16'(ctrl.flex) << KB_SHIFT;
				size.valid = 1'b1;
			end else if (!ctrl.size_extension) begin
				size.bytes = base;
				size.valid = 1'b1;
			end else if (ctrl.buffer_size_code != 2'h0) begin
				size.bytes = base << EXT_SHIFT;
				size.valid = 1'b1;
			end
		end
	end

endmodule

// File: hdl/rqbe_top.sv
// queue one receive control, buffer sizing and early receive dma start logic
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module rqbe_top (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [15:0] free_desc_count,
	input  wire logic        pkt_byte_vld,
	input  wire logic        pkt_last,
	input  wire logic        buf_other_data,
	input  wire logic        dma_gnt,
	output logic             pkt_ready,
	output logic             dma_req,
	output logic             dma_early,
	output logic             dma_go,
	output logic [15:0]      dma_len,
	output logic             desc_min_evt,
	output logic             q1_active,
	output logic [15:0]      q1_buf_bytes,
	output logic             q1_size_ok,
	output logic             q1_split_mode
);
	import rqbe_pkg::*;

	rqbe_bus_t      bus;
	logic [31:0]    rdata;
	rqbe_q1_ctrl_t  q1_q;
	rqbe_ert_t      ert_q;
	logic           vmq_q;
	logic [15:0]    ring_q;
	rqbe_size_t     size;
	logic           free_eq;
	logic           free_eq_q;
	logic           hit_q;
	rqbe_state_t    st_q;
	logic [15:0]    coll_q;
	logic [15:0]    sent_q;
	logic           done_q;
	logic           early_q;
	logic [15:0]    thr_bytes;
	logic           early_ok;
	logic           want_burst;
	logic           frame_close;

	// free fraction divisor as a shift; reserved code gives no match
	function automatic logic [2:0] free_shift(input logic [1:0] code);
		case (code)
			2'h0: free_shift = 3'd1;
			2'h1: free_shift = 3'd2;
			2'h2: free_shift = 3'd3;
			default: free_shift = 3'd0;
		endcase
	endfunction

	function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_addr);
		hit = (a == ref_addr);
	endfunction

	rqbe_ahb_slave u_slave (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.rdata     (rdata),
		.bus       (bus),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata)
	);

	rqbe_size_dec u_size (
		.ctrl (q1_q),
		.size (size)
	);

	// queue one control: only writable fields are stored
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q1_q <= {Q1_CTRL_RST[FLEX_LSB+:4], Q1_CTRL_RST[RSV26_BIT], Q1_CTRL_RST[SIZE_EXTENSION_BIT],
				Q1_CTRL_RST[BUFFER_SIZE_CODE_LSB+:2], Q1_CTRL_RST[FMT_LSB+:2],
				Q1_CTRL_RST[FREE_THR_LSB+:2]};
		end else if (bus.wr && hit(bus.addr, Q1_CTRL_ADDR)) begin
			q1_q.free_thr <= bus.wdata[FREE_THR_LSB+:2];
			q1_q.fmt      <= bus.wdata[FMT_LSB+:2];
			q1_q.buffer_size_code    <= bus.wdata[BUFFER_SIZE_CODE_LSB+:2];
			q1_q.size_extension     <= bus.wdata[SIZE_EXTENSION_BIT];
			q1_q.rsv26    <= bus.wdata[RSV26_BIT];
			q1_q.flex     <= bus.wdata[FLEX_LSB+:4];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ert_q <= {ERT_RST[ERT_HI_LSB+:7], ERT_RST[ERT_EN_BIT], ERT_RST[ERT_THR_LSB+:13]};
		end else if (bus.wr && hit(bus.addr, ERT_ADDR)) begin
			ert_q.thr <= bus.wdata[ERT_THR_LSB+:13];
			ert_q.en  <= bus.wdata[ERT_EN_BIT];
			ert_q.hi  <= bus.wdata[ERT_HI_LSB+:7];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			vmq_q  <= 1'b0;
			ring_q <= RING_RST;
		end else if (bus.wr && hit(bus.addr, Q_CFG_ADDR)) begin
			vmq_q  <= bus.wdata[CFG_VMQ_BIT];
			ring_q <= bus.wdata[CFG_RING_LSB+:16];
		end
	end

	// read mux; unmapped bits read zero, reserved bit 26 of queue one control reads back as written
	always_comb begin
		rdata = 32'h0000_0000;
		if (hit(bus.addr, Q1_CTRL_ADDR)) begin
			rdata[FREE_THR_LSB+:2] = q1_q.free_thr;
			rdata[FMT_LSB+:2]      = q1_q.fmt;
			rdata[BUFFER_SIZE_CODE_LSB+:2]    = q1_q.buffer_size_code;
			rdata[SIZE_EXTENSION_BIT]        = q1_q.size_extension;
			rdata[RSV26_BIT]       = q1_q.rsv26;
			rdata[FLEX_LSB+:4]     = q1_q.flex;
		end else if (hit(bus.addr, ERT_ADDR)) begin
			rdata[ERT_THR_LSB+:13] = ert_q.thr;
			rdata[ERT_EN_BIT]      = ert_q.en;
			rdata[ERT_HI_LSB+:7]   = ert_q.hi;
		end else if (hit(bus.addr, Q_CFG_ADDR)) begin
			rdata[CFG_VMQ_BIT]      = vmq_q;
			rdata[CFG_RING_LSB+:16] = ring_q;
		end else if (hit(bus.addr, ERT_STAT_ADDR)) begin
			rdata[15:0]         = coll_q;
			rdata[ST_REQ_BIT]   = dma_req;
			rdata[ST_EARLY_BIT] = early_q;
			rdata[ST_HIT_BIT]   = hit_q;
		end
	end

	// queue one settings only steer the second queue in virtual queue mode
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q1_active     <= 1'b0;
			q1_buf_bytes  <= 16'h0000;
			q1_size_ok    <= 1'b0;
			q1_split_mode <= 1'b0;
		end else begin
			q1_active     <= vmq_q;
			q1_buf_bytes  <= vmq_q ? size.bytes : 16'h0000;
			q1_size_ok    <= vmq_q && size.valid;
			q1_split_mode <= vmq_q && size.split;
		end
	end

	// free fraction match: free * divisor == ring length
	always_comb begin
		free_eq = (free_shift(q1_q.free_thr) != 3'd0) && (ring_q != 16'h0000)
			&& ({3'b000, free_desc_count} << free_shift(q1_q.free_thr))
			== {3'b000, ring_q};
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			free_eq_q    <= 1'b0;
			desc_min_evt <= 1'b0;
		end else begin
			free_eq_q    <= free_eq;
			desc_min_evt <= vmq_q && free_eq && !free_eq_q;
		end
	end

	// sticky status copy; a new hit beats the write-one clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hit_q <= 1'b0;
		end else if (desc_min_evt) begin
			hit_q <= 1'b1;
		end else if (bus.wr && hit(bus.addr, ERT_STAT_ADDR) && bus.wdata[ST_HIT_BIT]) begin
			hit_q <= 1'b0;
		end
	end

	// early start decision, re-evaluated every cycle
	always_comb begin
		thr_bytes   = {ert_q.thr, 3'b000};
		early_ok    = (ert_q.thr != 13'h0000) && !buf_other_data
			&& (coll_q >= thr_bytes);
		want_burst  = (coll_q != sent_q) && (done_q || early_q || early_ok);
		frame_close = (st_q == ST_IDLE) && done_q && (coll_q == sent_q);
	end

	// frame tracking: bytes stored, bytes moved, end seen
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			coll_q  <= 16'h0000;
			sent_q  <= 16'h0000;
			done_q  <= 1'b0;
			early_q <= 1'b0;
		end else if (frame_close) begin
			coll_q  <= 16'h0000;
			sent_q  <= 16'h0000;
			done_q  <= 1'b0;
			early_q <= 1'b0;
		end else begin
			if (pkt_byte_vld && pkt_ready) begin
				coll_q <= coll_q + 16'h0001;
				done_q <= pkt_last;
			end
			if (st_q == ST_REQ && dma_gnt) begin
				sent_q <= coll_q;
			end
			if (st_q == ST_IDLE && early_ok && !done_q) begin
				early_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pkt_ready <= 1'b1;
		end else begin
			pkt_ready <= !(done_q || (pkt_byte_vld && pkt_ready && pkt_last)) || frame_close;
		end
	end

	// dma request handshake with the host bus arbiter
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_q      <= ST_IDLE;
			dma_req   <= 1'b0;
			dma_early <= 1'b0;
			dma_go    <= 1'b0;
			dma_len   <= 16'h0000;
		end else begin
			dma_go <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (want_burst) begin
						st_q      <= ST_REQ;
						dma_req   <= 1'b1;
						dma_early <= !done_q;
					end
				end
				ST_REQ: begin
					if (dma_gnt) begin
						st_q    <= ST_IDLE;
						dma_req <= 1'b0;
						dma_go  <= 1'b1;
						dma_len <= coll_q - sent_q;
					end
				end
				default: begin
					st_q    <= ST_IDLE;
					dma_req <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	logic [15:0] pend_w;
	assign pend_w = coll_q - sent_q;

	rsvd_byte_a: assert property (
		bus.rd && hit(bus.addr, Q1_CTRL_ADDR) |=> hrdata[7:0] == 8'h00 && hreadyout)
		else $error("reserved control byte not zero");
	ert_high_a: assert property (
		bus.rd && hit(bus.addr, ERT_ADDR) |=> hrdata[31:22] == 10'h000)
		else $error("threshold high bits not zero");
	desc_event_a: assert property (
		vmq_q && free_eq && !free_eq_q |=> desc_min_evt)
		else $error("free threshold event missed");
	desc_once_a: assert property (
		desc_min_evt |=> !desc_min_evt)
		else $error("free threshold event repeated");
	base_size_a: assert property (
		vmq_q && q1_q.fmt == FMT_LEGACY && q1_q.flex == 4'h0 && !q1_q.size_extension
		&& q1_q.buffer_size_code == 2'h0 |=> q1_buf_bytes == 16'h0800 && q1_size_ok)
		else $error("base buffer size wrong");
	ext_size_a: assert property (
		vmq_q && q1_q.fmt == FMT_LEGACY && q1_q.flex == 4'h0 && q1_q.size_extension
		&& q1_q.buffer_size_code == 2'h1 |=> q1_buf_bytes == 16'h4000)
		else $error("extended buffer size wrong");
	ext_rsvd_a: assert property (
		vmq_q && q1_q.fmt == FMT_LEGACY && q1_q.flex == 4'h0 && q1_q.size_extension
		&& q1_q.buffer_size_code == 2'h0 |=> !q1_size_ok)
		else $error("reserved extended code accepted");
	flex_size_a: assert property (
		vmq_q && q1_q.fmt == FMT_LEGACY && q1_q.flex != 4'h0
		|=> q1_buf_bytes == {$past(q1_q.flex), 10'h000})
		else $error("flexible buffer size wrong");
	split_mode_a: assert property (
		vmq_q && q1_q.fmt == FMT_SPLIT |=> q1_split_mode && q1_buf_bytes == 16'h0000)
		else $error("split format not flagged");
	no_vmq_a: assert property (
		!vmq_q |=> !q1_active && !q1_size_ok)
		else $error("queue one active outside virtual mode");
	early_start_a: assert property (
		st_q == ST_IDLE && early_ok && !done_q && coll_q != sent_q |=> dma_req && dma_early)
		else $error("early transfer not started");
	hold_back_a: assert property (
		st_q == ST_IDLE && !done_q && !early_q && !early_ok |=> !dma_req)
		else $error("transfer started before threshold or end");
	other_data_a: assert property (
		st_q == ST_IDLE && !early_q && !done_q && buf_other_data |=> !dma_req)
		else $error("early start with other data buffered");
	burst_len_a: assert property (
		st_q == ST_REQ && dma_gnt |=> dma_go && dma_len == $past(pend_w) && !dma_req)
		else $error("burst length not all collected data");

	early_burst_c: cover property (dma_go && dma_early);
	end_burst_c: cover property (dma_go && !dma_early);
	desc_event_c: cover property (desc_min_evt);
	frame_close_c: cover property (frame_close ##1 pkt_ready);

endmodule

// File: verification/rqbe_host_model.sv
// host bus model: grants each dma request after a programmable delay
`timescale 1ns/1ps
module rqbe_host_model (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       dma_req,
	input  wire logic [7:0] lat,
	output logic            dma_gnt
);
	logic [7:0] wait_q;

	// one grant pulse per request; dropped with the request or once taken
	always_ff @(posedge sys_clk) begin
		if (!rstn || !dma_req || dma_gnt) begin
			wait_q  <= 8'h00;
			dma_gnt <= 1'b0;
		end else if (wait_q >= lat) begin
			dma_gnt <= 1'b1;
		end else begin
			wait_q <= wait_q + 8'h01;
		end
	end
endmodule

// File: verification/tb_top.sv
// self-checking bench: registers, buffer sizing, descriptor flag, early receive
`timescale 1ns/1ps
module tb_top;
	import rqbe_pkg::*;
	logic        sys_clk         = 1'b0;
	logic        rstn            = 1'b0;
	logic [31:0] haddr           = 32'h0000_0000;
	logic [1:0]  htrans          = 2'h0;
	logic        hwrite          = 1'b0;
	logic [31:0] hwdata          = 32'h0000_0000;
	logic [15:0] free_desc_count = 16'h0000;
	logic        pkt_byte_vld    = 1'b0;
	logic        pkt_last        = 1'b0;
	logic        buf_other_data  = 1'b0;
	logic [7:0]  lat             = 8'h00;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        dma_gnt;
	logic        pkt_ready;
	logic        dma_req;
	logic        dma_early;
	logic        dma_go;
	logic [15:0] dma_len;
	logic        desc_min_evt;
	logic        q1_active;
	logic [15:0] q1_buf_bytes;
	logic        q1_size_ok;
	logic        q1_split_mode;
	logic [16:0] log_q[$];
	int          evt_n;
	int          tot_n;
	int          fail_count;
	int          checked;
	logic [31:0] thr_v[3]  = '{32'h0000_0000, 32'h0000_200A, 32'h0000_2002};
	logic [31:0] ctl_v[3]  = '{32'h1A00_0000, 32'h7800_0000, 32'h0000_0800};
	logic [31:0] exp_v[3]  = '{32'h0006_0C00, 32'h0006_3C00, 32'h0004_0000};
	logic [15:0] b;

	always #5 sys_clk = ~sys_clk;

	rqbe_top rqbe_top_i (
		.sys_clk(sys_clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.free_desc_count(free_desc_count), .pkt_byte_vld(pkt_byte_vld), .pkt_last(pkt_last),
		.buf_other_data(buf_other_data), .dma_gnt(dma_gnt), .pkt_ready(pkt_ready),
		.dma_req(dma_req), .dma_early(dma_early), .dma_go(dma_go), .dma_len(dma_len),
		.desc_min_evt(desc_min_evt), .q1_active(q1_active), .q1_buf_bytes(q1_buf_bytes),
		.q1_size_ok(q1_size_ok), .q1_split_mode(q1_split_mode)
	);

	rqbe_host_model rqbe_host_model_i (
		.sys_clk(sys_clk), .rstn(rstn), .dma_req(dma_req), .lat(lat), .dma_gnt(dma_gnt)
	);

	// log every burst start and every threshold flag pulse
	always @(posedge sys_clk) begin
		if (dma_go === 1'b1) begin
			log_q.push_back({dma_early, dma_len});
			tot_n = tot_n + int'(dma_len);
		end
		if (desc_min_evt === 1'b1) begin
			evt_n++;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] r);
		htrans <= HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= wr;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask

	task automatic send(input int n, input logic last);
		for (int i = 0; i < n; i++) begin
			pkt_byte_vld <= 1'b1;
			pkt_last     <= last && (i == n - 1);
			@(posedge sys_clk);
		end
		pkt_byte_vld <= 1'b0;
		pkt_last     <= 1'b0;
	endtask

	// wait for the frame slot to reopen after the final burst
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 200 && pkt_ready !== 1'b1; i++) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
	endtask

	function automatic logic [31:0] q1v();
		return {13'h0000, q1_active, q1_size_ok, q1_split_mode, q1_buf_bytes};
	endfunction

	task automatic test_done();
		$display("checks %0d failures %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#100_000;
		fail_count++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({hresp, pkt_ready, dma_req}, 32'h0000_0002);
		rd_chk(Q1_CTRL_ADDR, Q1_CTRL_RST);
		rd_chk(ERT_ADDR, ERT_RST);
		wr(Q1_CTRL_ADDR, 32'hFFFF_FFFF);
		rd_chk(Q1_CTRL_ADDR, 32'h7E03_0F00);
		wr(ERT_ADDR, 32'hFFFF_FFFF);
		rd_chk(ERT_ADDR, 32'h003F_BFFF);
		rd_chk(32'h0000_0200, 32'h0000_0000);
		// ring of 64 descriptors, virtual queue mode on
		wr(Q_CFG_ADDR, 32'h0040_0001);
		for (int c = 0; c < 8; c++) begin
			wr(Q1_CTRL_ADDR, {6'h00, c[2], 7'h00, c[1:0], 16'h0000});
			repeat (3) @(posedge sys_clk);
			b = BUF_2048 >> c[1:0];
			if (c[2]) b = (c[1:0] == 2'h0) ? 16'h0000 : b << 4;
			chk(q1v(), {13'h0000, 1'b1, !(c[2] && c[1:0] == 2'h0), 1'b0, b});
		end
		for (int k = 0; k < 3; k++) begin
			wr(Q1_CTRL_ADDR, ctl_v[k]);
			repeat (3) @(posedge sys_clk);
			chk(q1v(), exp_v[k]);
		end
		wr(Q1_CTRL_ADDR, 32'h0001_0400);
		repeat (3) @(posedge sys_clk);
		chk({q1_split_mode, q1_buf_bytes}, 32'h0001_0000);
		for (int k = 0; k < 4; k++) begin
			free_desc_count <= 16'h0000;
			wr(Q1_CTRL_ADDR, k << 8);
			evt_n = 0;
			free_desc_count <= 16'h0020 >> k;
			repeat (8) @(posedge sys_clk);
			chk(evt_n, (k < 3) ? 1 : 0);
		end
		wr(Q_CFG_ADDR, 32'h0040_0000);
		repeat (3) @(posedge sys_clk);
		chk(q1v(), 32'h0000_0000);
		// zero, short-packet and busy-buffer cases give one burst after the end
		for (int k = 0; k < 3; k++) begin
			wr(ERT_ADDR, thr_v[k]);
			buf_other_data <= (k == 2);
			log_q.delete();
			tot_n = 0;
			send(24, 1'b1);
			settle();
			chk(log_q.size(), 1);
			chk(log_q[0], 32'h0000_0018);
		end
		// early start exactly at 16 bytes, with a slow host
		buf_other_data <= 1'b0;
		lat <= 8'h05;
		wr(ERT_ADDR, 32'h0000_2002);
		log_q.delete();
		tot_n = 0;
		send(15, 1'b0);
		repeat (10) @(posedge sys_clk);
		chk(dma_req, 1'b0);
		send(1, 1'b0);
		for (int i = 0; i < 100 && log_q.size() < 1; i++) @(posedge sys_clk);
		chk(log_q[0], 32'h0001_0010);
		send(8, 1'b1);
		settle();
		chk(tot_n, 24);
		// split format on queue one, jumbo-style threshold above any header
		wr(Q1_CTRL_ADDR, 32'h0000_0400);
		wr(ERT_ADDR, 32'h0000_20FA);
		rd_chk(ERT_ADDR, 32'h0000_20FA);
		test_done();
	end
endmodule
